//--- hw/purdt_pkg.sv
// constants and types for the power-up reset delay timer
package purdt_pkg;

  // ============================================================
  // clocking
  localparam int unsigned CLK_PERIOD_NS = 40;
  // internal rc clock period, 32 us
  localparam int unsigned RC_PERIOD_NS = 32000;
  // ref clock cycles per rc period, least time rounds up
  localparam int unsigned RC_TICK_CYC_DEF = (RC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ============================================================
  // counter layout
  localparam int unsigned PUD_CNT_W = 11;
  localparam logic [PUD_CNT_W-1:0] PUD_CNT_LAST = 11'h7FF;
  localparam logic [PUD_CNT_W-1:0] PUD_CNT_RST = 11'h000;
  localparam int unsigned DIV_W = 16;
  localparam logic [DIV_W-1:0] DIV_RST = 16'h0000;

  // ============================================================
  // synchroniser layout and reset values
  localparam int unsigned SYNC_W = 2;
  localparam int unsigned SYNC_POR_BIT = 1;
  localparam int unsigned SYNC_PIN_BIT = 0;
  // por asserted, pin low: the safe side until real levels arrive
  localparam logic [SYNC_W-1:0] SYNC_RST = 2'h2;

  // ============================================================
  // sequencer states
  typedef enum logic [1:0] {
    PURDT_ST_POR = 2'b00,
    PURDT_ST_COUNT = 2'b01,
    PURDT_ST_EXPIRED = 2'b10
  } purdt_state_e;

endpackage : purdt_pkg

//--- hw/purdt_tick_if.sv
// rc tick link between the sequencer and the rc tick generator
`timescale 1ns/1ps
interface purdt_tick_if;
  logic run;
  logic tick;

  modport gen (
    input run,
    output tick
  );

  modport use_side (
    output run,
    input tick
  );
endinterface : purdt_tick_if

//--- hw/purdt_rc_tick.sv
// internal rc clock period tick generator
`timescale 1ns/1ps
module purdt_rc_tick
  import purdt_pkg::*;
#(
  parameter int unsigned RC_TICK_CYC = RC_TICK_CYC_DEF
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  purdt_tick_if.gen tick_if
);

  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] nxt_div;
  logic tick_ff;
  logic nxt_tick;

  // ============================================================
  // divider
  // cleared while idle so the first period after start is whole
  always_comb begin
    nxt_div = DIV_RST;
    nxt_tick = 1'b0;
    if (tick_if.run) begin
      if (div_ff == DIV_W'(RC_TICK_CYC - 1)) begin
        nxt_tick = 1'b1;
      end else begin
        nxt_div = div_ff + DIV_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      div_ff <= DIV_RST;
      tick_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_if.tick = tick_ff;

  // ============================================================
  // checks
  a_tick_period: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (tick_if.run && div_ff == DIV_W'(RC_TICK_CYC - 1)) |=> tick_ff)
    else $error("rc tick missing at end of period");

endmodule : purdt_rc_tick

//--- hw/purdt_top.sv
// power-up reset delay timer: stretches power-on reset by 2048 rc periods
`timescale 1ns/1ps

module purdt_top
  import purdt_pkg::*;
#(
  parameter int unsigned RC_TICK_CYC = RC_TICK_CYC_DEF
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic por_pulse_i,
  input wire logic external_reset_pin_n_i,
  output logic core_reset_o,
  output logic delay_active_o,
  output logic delay_expired_o,
  output logic [PUD_CNT_W-1:0] delay_count_o
);

  // ============================================================
  // declarations
  purdt_tick_if tick_if ();

  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;
  logic [SYNC_W-1:0] nxt_sync1;
  logic [SYNC_W-1:0] nxt_sync2;
  logic por_s;
  logic pin_high;

  purdt_state_e state_ff;
  purdt_state_e nxt_state;
  logic [PUD_CNT_W-1:0] power_up_delay_counter_ff;
  logic [PUD_CNT_W-1:0] nxt_power_up_delay_counter;
  logic core_reset_ff;
  logic nxt_core_reset;
  logic expired_ff;
  logic nxt_expired;
  logic active_ff;
  logic nxt_active;

  // ============================================================
  // state decode
  function automatic logic purdt_is_count(input purdt_state_e st);
    return st == PURDT_ST_COUNT;
  endfunction : purdt_is_count

  function automatic logic purdt_is_expired(input purdt_state_e st);
    return st == PURDT_ST_EXPIRED;
  endfunction : purdt_is_expired

  // ============================================================
  // input synchronisers
  // both levels come from outside this clock: por from analog, pin from the board
  always_comb begin
    nxt_sync1 = SYNC_W'(0);
    nxt_sync1[SYNC_POR_BIT] = por_pulse_i;
    nxt_sync1[SYNC_PIN_BIT] = external_reset_pin_n_i;
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      sync1_ff <= SYNC_RST;
      sync2_ff <= SYNC_RST;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  assign por_s = sync2_ff[SYNC_POR_BIT];
  assign pin_high = sync2_ff[SYNC_PIN_BIT];

  // ============================================================
  // rc period tick source
  purdt_rc_tick #(
    .RC_TICK_CYC(RC_TICK_CYC)
  ) u_rc_tick (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .tick_if(tick_if.gen)
  );

  // divider held clear outside counting so each count starts on a whole period
  assign tick_if.run = purdt_is_count(state_ff) && !por_s;

  // ============================================================
  // delay sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_power_up_delay_counter = power_up_delay_counter_ff;
    case (state_ff)
      PURDT_ST_POR: begin
        nxt_power_up_delay_counter = PUD_CNT_RST;
        if (!por_s) begin
          nxt_state = PURDT_ST_COUNT;
        end
      end
      PURDT_ST_COUNT: begin
        // pin level plays no part while counting
        if (tick_if.tick) begin
          if (power_up_delay_counter_ff == PUD_CNT_LAST) begin
            nxt_state = PURDT_ST_EXPIRED;
          end else begin
            nxt_power_up_delay_counter = power_up_delay_counter_ff + PUD_CNT_W'(1);
          end
        end
      end
      PURDT_ST_EXPIRED: begin
        nxt_state = PURDT_ST_EXPIRED;
      end
      default: begin
        nxt_state = PURDT_ST_POR;
        nxt_power_up_delay_counter = PUD_CNT_RST;
      end
    endcase
    // a fresh por pulse restarts the whole sequence
    if (por_s) begin
      nxt_state = PURDT_ST_POR;
      nxt_power_up_delay_counter = PUD_CNT_RST;
    end
  end

  // release needs expiry and a high pin; expiry first means release follows the pin edge
  always_comb begin
    nxt_expired = purdt_is_expired(nxt_state);
    nxt_active = purdt_is_count(nxt_state);
    nxt_core_reset = !(purdt_is_expired(nxt_state) && pin_high);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state_ff <= PURDT_ST_POR;
      power_up_delay_counter_ff <= PUD_CNT_RST;
      core_reset_ff <= 1'b1;
      expired_ff <= 1'b0;
      active_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      power_up_delay_counter_ff <= nxt_power_up_delay_counter;
      core_reset_ff <= nxt_core_reset;
      expired_ff <= nxt_expired;
      active_ff <= nxt_active;
    end
  end

  // ============================================================
  // outputs
  assign core_reset_o = core_reset_ff;
  assign delay_expired_o = expired_ff;
  assign delay_active_o = active_ff;
  assign delay_count_o = power_up_delay_counter_ff;

  // ============================================================
  // checks
  sequence s_por_falls;
    por_s ##1 !por_s;
  endsequence

  sequence s_last_tick;
    (state_ff == PURDT_ST_COUNT) && tick_if.tick && (power_up_delay_counter_ff == PUD_CNT_LAST) && !por_s;
  endsequence

  sequence s_pin_rises_late;
    ((state_ff == PURDT_ST_EXPIRED) && !pin_high && !por_s) ##1 (pin_high && !por_s);
  endsequence

  a_hold_while_count: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (state_ff == PURDT_ST_COUNT) |-> core_reset_o)
    else $error("core reset released while counting");

  a_start_after_por: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    s_por_falls |=> (state_ff == PURDT_ST_COUNT) && (power_up_delay_counter_ff == PUD_CNT_RST))
    else $error("count did not start after por ended");

  a_no_start_in_por: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    por_s |=> (state_ff == PURDT_ST_POR) && core_reset_o)
    else $error("sequence left por state while por active");

  a_count_steps: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ((state_ff == PURDT_ST_COUNT) && !por_s && tick_if.tick && (power_up_delay_counter_ff != PUD_CNT_LAST))
    |=> (power_up_delay_counter_ff == $past(power_up_delay_counter_ff) + PUD_CNT_W'(1)))
    else $error("delay counter did not step on rc tick");

  a_count_holds: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ((state_ff == PURDT_ST_COUNT) && !por_s && !tick_if.tick) |=> $stable(power_up_delay_counter_ff))
    else $error("delay counter moved without rc tick");

  a_expire_at_end: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    s_last_tick |=> (state_ff == PURDT_ST_EXPIRED) && delay_expired_o)
    else $error("no expiry after last rc period");

  a_pin_ignored: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ((state_ff == PURDT_ST_COUNT) && !pin_high && !por_s && tick_if.tick && (power_up_delay_counter_ff == PUD_CNT_LAST))
    |=> (state_ff == PURDT_ST_EXPIRED) && core_reset_o)
    else $error("low pin stalled the delay count");

  a_release_now: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    s_pin_rises_late |=> !core_reset_o)
    else $error("release late after pin rose past expiry");

  a_release_needs_both: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    $fell(core_reset_o) |-> $past(pin_high) && (state_ff == PURDT_ST_EXPIRED))
    else $error("core reset released without expiry and high pin");

  a_pin_low_holds: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !pin_high |=> core_reset_o)
    else $error("core reset released with pin low");

  a_por_clears_all: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    por_s |=> !delay_expired_o && !delay_active_o && (delay_count_o == PUD_CNT_RST))
    else $error("por did not clear the delay state");

  a_expiry_sticks: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ((state_ff == PURDT_ST_EXPIRED) && !por_s) |=> (state_ff == PURDT_ST_EXPIRED) && delay_expired_o)
    else $error("expiry lost without por");

endmodule : purdt_top

//--- tb/purdt_pin_model.sv
// model of the outside circuit that drives the external reset pin
`timescale 1ns/1ps
module purdt_pin_model (
  input wire logic hold_low_i,
  output logic pin_n_o
);
  // ============================================================
  // pin driver
  // open drain with pull-up: released pin reads high, never the last level
  assign pin_n_o = ~hold_low_i;
endmodule : purdt_pin_model

//--- tb/tb_top.sv
// self-checking bench for the power-up reset delay timer
`timescale 1ns/1ps
module tb_top;
  import purdt_pkg::*;
  // short rc period keeps the 2048-period delay inside the run budget
  localparam int unsigned RC = 2;
  localparam int EXP = 2048 * RC + 4;
  typedef struct {logic core; int lo; int hi;} purdt_note_s;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic por_pulse_i = 1'b1;
  logic hold_low = 1'b0;
  logic pin_n;
  logic core_reset_o;
  logic delay_active_o;
  logic delay_expired_o;
  logic [PUD_CNT_W-1:0] delay_count_o;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  int seed = 32'h9aa48665;
  logic core_q = 1'b1;
  logic exp_q = 1'b0;
  purdt_note_s notes[$];
  purdt_note_s wn;

  purdt_top #(.RC_TICK_CYC(RC)) u_dut (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .por_pulse_i(por_pulse_i),
    .external_reset_pin_n_i(pin_n),
    .core_reset_o(core_reset_o),
    .delay_active_o(delay_active_o),
    .delay_expired_o(delay_expired_o),
    .delay_count_o(delay_count_o)
  );

  purdt_pin_model u_pin (
    .hold_low_i(hold_low),
    .pin_n_o(pin_n)
  );

  initial begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
  end

  // ============================================================
  // helpers
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : cycles

  // drive pin or por at an edge; hi above zero files a note of the event
  task automatic stim(input bit pin, input logic v, input logic core, input int lo, input int hi);
    @(posedge ref_clk_i);
    if (pin) begin
      hold_low <= v;
    end else begin
      por_pulse_i <= v;
    end
    #1;
    if (hi > 0) begin
      notes.push_back('{core, cyc + lo, cyc + hi});
    end
  endtask : stim

  task automatic drain(input int lim);
    int k;
    k = 0;
    while (notes.size() != 0 && k < lim) begin
      @(posedge ref_clk_i);
      k++;
    end
    if (notes.size() != 0) begin
      chk(1'b0, "event never came");
      close_out();
    end
  endtask : drain

  // ============================================================
  // watcher: release or expiry edge takes the oldest note
  always @(negedge ref_clk_i) begin
    if (resetn_i && ((core_q && !core_reset_o) || (!exp_q && delay_expired_o))) begin
      if (notes.size() == 0) begin
        chk(1'b0, "unexpected release or expiry");
      end else begin
        wn = notes.pop_front();
        chk(core_reset_o === wn.core && delay_expired_o === 1'b1, "event levels");
        chk(cyc >= wn.lo && cyc <= wn.hi, "event time");
      end
    end
    core_q = core_reset_o;
    exp_q = delay_expired_o;
  end

  // ============================================================
  // main sequence
  initial begin
    cycles(7);
    #1 chk(core_reset_o === 1'b1 && delay_active_o === 1'b0 && delay_count_o === PUD_CNT_RST, "reset");
    @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    cycles(20 + ($random(seed) & 63));
    #1 chk(delay_active_o === 1'b0 && delay_count_o === PUD_CNT_RST, "count under por");
    stim(1'b0, 1'b0, 1'b0, EXP - 2, EXP + 2);
    cycles(1004);
    #1 chk(core_reset_o === 1'b1 && delay_active_o === 1'b1, "held while counting");
    chk(delay_count_o >= 11'h1F0 && delay_count_o <= 11'h1F8, "count rate");
    drain(EXP + 8);
    #1 chk(delay_active_o === 1'b0, "still active after expiry");
    stim(1'b1, 1'b1, 1'b0, 0, 0);
    cycles(4);
    #1 chk(core_reset_o === 1'b1 && delay_expired_o === 1'b1, "pin low not honoured");
    // restart in mid-count with the pin held low
    stim(1'b0, 1'b1, 1'b0, 0, 0);
    cycles(4);
    stim(1'b0, 1'b0, 1'b0, 0, 0);
    cycles(100 + ($random(seed) & 255));
    stim(1'b0, 1'b1, 1'b0, 0, 0);
    cycles(4);
    #1 chk(delay_active_o === 1'b0 && delay_count_o === PUD_CNT_RST, "por restart");
    stim(1'b0, 1'b0, 1'b1, EXP - 2, EXP + 2);
    drain(EXP + 8);
    cycles($random(seed) & 31);
    #1 chk(core_reset_o === 1'b1, "released with pin low");
    // two synchroniser stages plus the release register: three edges from the pin
    stim(1'b1, 1'b0, 1'b0, 3, 3);
    drain(10);
    // block reset in mid-run restarts the whole sequence
    @(posedge ref_clk_i);
    resetn_i <= 1'b0;
    cycles(2);
    #1 chk(core_reset_o === 1'b1 && delay_active_o === 1'b0, "mid-run reset core");
    chk(delay_expired_o === 1'b0 && delay_count_o === PUD_CNT_RST, "mid-run reset count");
    @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    #1 notes.push_back('{1'b0, cyc + EXP - 2, cyc + EXP + 2});
    drain(EXP + 8);
    close_out();
  end
endmodule : tb_top
